// File: logic/gpp_defs.svh
// Purpose: Constants of the pin port block.
// Assumes: Byte-wide registers on a five-bit address.
// Notes: Definitions only.
`ifndef GPP_DEFS_SVH
`define GPP_DEFS_SVH
`define GPP_OFS_DIR   5'h00
`define GPP_OFS_DSET  5'h01
`define GPP_OFS_DCLR  5'h02
`define GPP_OFS_DTGL  5'h03
`define GPP_OFS_OUT   5'h04
`define GPP_OFS_OSET  5'h05
`define GPP_OFS_OCLR  5'h06
`define GPP_OFS_OTGL  5'h07
`define GPP_OFS_IN    5'h08
`define GPP_OFS_FLAG  5'h09
`define GPP_OFS_GRP   5'h0A
`define GPP_OFS_CFG   5'h10
`define GPP_OFS_CFGL  5'h17
`define GPP_OFS_ADIR  5'h18
`define GPP_OFS_AOUT  5'h19
`define GPP_OFS_AIN   5'h1A
`define GPP_OFS_AFLG  5'h1B
`define GPP_CFG_INV   7
`define GPP_CFG_PULL  3
`define GPP_GRP_SLR   0
`define GPP_CFG_MASK  8'h8F
`define GPP_IBUF_RST  8'hFF
`define GPP_ZERO      8'h00
`define GPP_DEAD      2'h3
`endif

// File: logic/gpp_pkg.sv
// Purpose: Types of the pin port block.
// Assumes: At most eight pins per instance.
// Notes: State is one packed struct.
package gpp_pkg;
    typedef enum logic [2:0] {
        GPP_INTDIS = 3'h0,
        GPP_BOTH   = 3'h1,
        GPP_RISE   = 3'h2,
        GPP_FALL   = 3'h3,
        GPP_BUFOFF = 3'h4,
        GPP_LOW    = 3'h5
    } gpp_sense_e;
    typedef struct packed {
        logic [4:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } gpp_bus_s;
    typedef struct packed {
        logic [7:0]      dir, out, smp, flags, filt, s1, s2, s3, prev;
        logic [7:0][7:0] cfg;
        logic [7:0][1:0] dead;
        logic            edge_rate_limit;
        logic [7:0]      rdata, pin_o, pin_oe, pull, evt, ibuf;
        logic            irq, wake;
    } gpp_state_s;
endpackage

// File: logic/gpp_port.sv
// Purpose: Pin port with direction, level, sensing and fast aliases.
// Assumes: Bus strobes last one cycle; read data follow one cycle later.
// Notes: Pins beyond the pin count read as zero and never drive.
// Operation
// R1 - Reset tri-states all drivers and enables all input buffers, clock or not.
// R2 - Up to eight pins; bit n of mask and level governs pin n.
// R3 - Drive-enable set writes ones into the drive-enable mask.
// R4 - Drive-enable clear writes zeros into the mask where ones are written.
// R5 - Drive-enable flip inverts mask bits where ones are written.
// R6 - Drive-level set forces level bits to one where ones are written.
// R7 - Drive-level clear forces level bits to zero where ones are written.
// R8 - Level flip or sampled-level writes invert level bits where ones are written.
// R9 - Pin inputs are synchronised and readable as sampled level in any direction.
// R10 - Buffer-off sense freezes the filter stage and sampled bit and turns the input buffer off.
// R11 - Edge-rate-limit bit limits slew on all pins of the instance.
// R12 - Pin n configuration sits at base plus 0x10 plus n.
// R13 - Polarity swap inverts input and output of that pin; the code leaves the level of a peripheral-overridden pin uninverted.
// R14 - Changing polarity swap makes an edge seen by sensing and users.
// R15 - Weak pull-up connects only while the pin driver is off.
// R16 - Sense select covers both edges, rising, falling and low level.
// R17 - Pin change sensing raises a wake request.
// R18 - Fast aliases of mask, level, sampled level and flags act identically.
// R19 - Enabled peripherals override a pin; others stay ordinary I/O.
// R20 - Sense hit sets the flag; request stands while flag set and enabled.
// R21 - No new pin interrupt for three cycles after one.
// R22 - Event output follows pin value while buffer on, else zero.
// R23 - Sense codes: off, both, rise, fall, buffer off, low level.
// R24 - Writing one to a flag clears it; zero leaves it.
`timescale 1ns/1ps
`include "gpp_defs.svh"

module gpp_port #(
    parameter int NPIN = 8
) (
    input  wire logic         clk_in,
    input  wire logic         nrst_in,
    input  gpp_pkg::gpp_bus_s bus_in,
    output logic [7:0]        rdata_out,
    input  wire logic [NPIN-1:0] pin_in,
    output logic [NPIN-1:0]   pin_out,
    output logic [NPIN-1:0]   pin_oe_out,
    output logic [NPIN-1:0]   pull_out,
    output logic [NPIN-1:0]   ibuf_en_out,
    output logic [NPIN-1:0]   evt_out,
    output logic              slew_out,
    output logic              irq_out,
    output logic              wake_out,
    input  wire logic [NPIN-1:0] ovr_en_in,
    input  wire logic [NPIN-1:0] ovr_oe_in,
    input  wire logic [NPIN-1:0] ovr_lvl_in
);

    // ****************************************
    // Checks and helpers
    // ****************************************
    if (NPIN < 1 || NPIN > 8) begin : g_bad_npin
        $error("NPIN must lie between 1 and 8");
    end

    localparam logic [7:0] PMASK = 8'((9'h001 << NPIN) - 9'h001);

    // Alias addresses fold onto the base registers.
    function automatic logic [4:0] canon(input logic [4:0] a);
        case (a)
            `GPP_OFS_ADIR: canon = `GPP_OFS_DIR;
            `GPP_OFS_AOUT: canon = `GPP_OFS_OUT;
            `GPP_OFS_AIN:  canon = `GPP_OFS_IN;
            `GPP_OFS_AFLG: canon = `GPP_OFS_FLAG;
            default:       canon = a;
        endcase
    endfunction

    // Sense hit of one pin from new and previous internal value.
    function automatic logic hit(input logic [2:0] sense_select,
                                 input logic v,
                                 input logic p);
        case (sense_select)
            gpp_pkg::GPP_BOTH: hit = v ^ p;
            gpp_pkg::GPP_RISE: hit = v & ~p;
            gpp_pkg::GPP_FALL: hit = ~v & p;
            gpp_pkg::GPP_LOW:  hit = ~v;
            default:           hit = 1'b0;
        endcase
    endfunction

    function automatic logic sense_on(input logic [2:0] sense_select); // see R23
        sense_on = sense_select == gpp_pkg::GPP_BOTH || sense_select == gpp_pkg::GPP_RISE ||
                   sense_select == gpp_pkg::GPP_FALL || sense_select == gpp_pkg::GPP_LOW;
    endfunction

    // ****************************************
    // State
    // ****************************************
    gpp_pkg::gpp_state_s st;
    gpp_pkg::gpp_state_s next_st;
    logic [7:0] pin_ext;
    logic [7:0] ovr_en;
    logic [7:0] ovr_oe;
    logic [7:0] ovr_lvl;
    logic [4:0] wa;
    logic [4:0] ra;
    logic [7:0] wd;
    logic [7:0] inv;
    logic [7:0] v;
    logic [7:0] ev;
    logic [7:0] oe_eff;
    logic [2:0] sense_select;
    logic [7:0] ena;

    always_comb begin
        pin_ext = '0;
        ovr_en  = '0;
        ovr_oe  = '0;
        ovr_lvl = '0;
        pin_ext[NPIN-1:0] = pin_in;
        ovr_en[NPIN-1:0]  = ovr_en_in;
        ovr_oe[NPIN-1:0]  = ovr_oe_in;
        ovr_lvl[NPIN-1:0] = ovr_lvl_in;
    end

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        next_st = st;
        wa = canon(bus_in.addr);
        ra = canon(bus_in.addr);
        wd = bus_in.wdata & PMASK;
        inv = '0;
        v = '0;
        ev = '0;
        oe_eff = '0;
        sense_select = '0;
        ena = '0;
        // Synchroniser stages.
        next_st.s1 = pin_ext;
        next_st.s2 = st.s1;
        next_st.s3 = st.s2;
        if (bus_in.wr) begin
            case (wa)
                `GPP_OFS_DIR:  next_st.dir = wd;
                `GPP_OFS_DSET: next_st.dir = st.dir | wd;  // see R3
                `GPP_OFS_DCLR: next_st.dir = st.dir & ~wd; // see R4
                `GPP_OFS_DTGL: next_st.dir = st.dir ^ wd;  // see R5
                `GPP_OFS_OUT:  next_st.out = wd;
                `GPP_OFS_OSET: next_st.out = st.out | wd;  // see R6
                `GPP_OFS_OCLR: next_st.out = st.out & ~wd; // see R7
                `GPP_OFS_OTGL: next_st.out = st.out ^ wd;  // see R8
                `GPP_OFS_IN:   next_st.out = st.out ^ wd;  // see R8 R18
                `GPP_OFS_GRP:  next_st.edge_rate_limit = bus_in.wdata[`GPP_GRP_SLR]; // see R11
                default: begin
                end
            endcase
            for (int n = 0; n < NPIN; n++) begin
                if (wa == 5'(`GPP_OFS_CFG + n)) begin
                    next_st.cfg[n] = bus_in.wdata & `GPP_CFG_MASK; // see R12
                end
            end
        end
        for (int n = 0; n < 8; n++) begin
            inv[n] = next_st.cfg[n][`GPP_CFG_INV];
            sense_select = next_st.cfg[n][2:0];
            ena[n] = sense_on(st.cfg[n][2:0]);
            // A change counts once stages two and three agree.
            if (sense_select != gpp_pkg::GPP_BUFOFF && st.s2[n] == st.s3[n]) begin
                next_st.filt[n] = st.s3[n]; // see R9
            end
            v[n] = next_st.filt[n] ^ inv[n]; // see R13 R14
            if (sense_select != gpp_pkg::GPP_BUFOFF) begin
                next_st.smp[n] = v[n];  // see R9 R10
                next_st.prev[n] = v[n];
                ev[n] = hit(sense_select, v[n], st.prev[n]) & PMASK[n]; // see R16
            end
            next_st.ibuf[n] = (sense_select != gpp_pkg::GPP_BUFOFF) & PMASK[n]; // see R10
            next_st.evt[n] = next_st.ibuf[n] & v[n]; // see R22
            if (st.dead[n] != 2'h0) begin
                next_st.dead[n] = st.dead[n] - 2'h1;
            end
            if (ev[n] && st.dead[n] == 2'h0) begin
                next_st.dead[n] = `GPP_DEAD; // see R21
            end else begin
                ev[n] = 1'b0;
            end
        end
        // Clear by one, but a new event wins over the clear.
        if (bus_in.wr && wa == `GPP_OFS_FLAG) begin
            next_st.flags = st.flags & ~wd; // see R24 R18
        end
        next_st.flags = next_st.flags | ev; // see R20
        next_st.irq = |(st.flags & ena); // see R20
        next_st.wake = |ev; // see R17
        for (int n = 0; n < 8; n++) begin
            oe_eff[n] = (ovr_en[n] ? ovr_oe[n] : st.dir[n]) & PMASK[n]; // see R19 R2
            next_st.pin_o[n] = ovr_en[n] ? ovr_lvl[n]
                                         : (st.out[n] ^ st.cfg[n][`GPP_CFG_INV]); // see R13
            next_st.pull[n] = st.cfg[n][`GPP_CFG_PULL] & ~oe_eff[n] & PMASK[n]; // see R15
        end
        next_st.pin_o = next_st.pin_o & PMASK;
        next_st.pin_oe = oe_eff;
        // Read data stand in the cycle after the strobe only.
        next_st.rdata = `GPP_ZERO;
        if (bus_in.rd) begin
            case (ra)
                `GPP_OFS_DIR, `GPP_OFS_DSET,
                `GPP_OFS_DCLR, `GPP_OFS_DTGL: next_st.rdata = st.dir;
                `GPP_OFS_OUT, `GPP_OFS_OSET,
                `GPP_OFS_OCLR, `GPP_OFS_OTGL: next_st.rdata = st.out;
                `GPP_OFS_IN:   next_st.rdata = st.smp;
                `GPP_OFS_FLAG: next_st.rdata = st.flags;
                `GPP_OFS_GRP:  next_st.rdata = {7'h00, st.edge_rate_limit};
                default: begin
                end
            endcase
            for (int n = 0; n < NPIN; n++) begin
                if (ra == 5'(`GPP_OFS_CFG + n)) begin
                    next_st.rdata = st.cfg[n];
                end
            end
        end
    end

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            st <= '{ibuf: `GPP_IBUF_RST, default: '0}; // see R1
        end else begin
            st <= next_st;
        end
    end

    assign rdata_out   = st.rdata;
    assign pin_out     = st.pin_o[NPIN-1:0];
    assign pin_oe_out  = st.pin_oe[NPIN-1:0];
    assign pull_out    = st.pull[NPIN-1:0];
    assign ibuf_en_out = st.ibuf[NPIN-1:0];
    assign evt_out     = st.evt[NPIN-1:0];
    assign slew_out    = st.edge_rate_limit;
    assign irq_out     = st.irq;
    assign wake_out    = st.wake;

    // ****************************************
    // Assertions
    // ****************************************
    a_reset_tristate: assert property ( // see R1
        @(posedge clk_in) disable iff (!nrst_in)
        $rose(nrst_in) |-> (st.pin_oe == '0 && st.dir == '0))
        else $error("Drivers not off after reset.");

    a_dir_set: assert property ( // see R3
        @(posedge clk_in) disable iff (!nrst_in)
        (bus_in.wr && bus_in.addr == `GPP_OFS_DSET) |=>
        ((st.dir & $past(bus_in.wdata) & PMASK) == ($past(bus_in.wdata) & PMASK)))
        else $error("Drive-enable set failed.");

    a_dir_clear: assert property ( // see R4
        @(posedge clk_in) disable iff (!nrst_in)
        (bus_in.wr && bus_in.addr == `GPP_OFS_DCLR) |=>
        ((st.dir & $past(bus_in.wdata)) == '0))
        else $error("Drive-enable clear failed.");

    a_dir_flip: assert property ( // see R5
        @(posedge clk_in) disable iff (!nrst_in)
        (bus_in.wr && bus_in.addr == `GPP_OFS_DTGL) |=>
        (st.dir == ($past(st.dir) ^ ($past(bus_in.wdata) & PMASK))))
        else $error("Drive-enable flip failed.");

    a_level_clear: assert property ( // see R7
        @(posedge clk_in) disable iff (!nrst_in)
        (bus_in.wr && bus_in.addr == `GPP_OFS_OCLR) |=>
        ((st.out & $past(bus_in.wdata)) == '0))
        else $error("Drive-level clear failed.");

    a_alias_flip: assert property ( // see R8
        @(posedge clk_in) disable iff (!nrst_in)
        (bus_in.wr && bus_in.addr == `GPP_OFS_AIN) |=>
        (st.out == ($past(st.out) ^ ($past(bus_in.wdata) & PMASK))))
        else $error("Alias flip failed.");

    a_pull_gate: assert property ( // see R15
        @(posedge clk_in) disable iff (!nrst_in)
        ##1 ((st.pull & st.pin_oe) == '0))
        else $error("Pull-up on while driving.");

    a_event_zero: assert property ( // see R22
        @(posedge clk_in) disable iff (!nrst_in)
        ((st.evt & ~st.ibuf) == '0))
        else $error("Event output with buffer off.");

    a_dead_time: assert property ( // see R21
        @(posedge clk_in) disable iff (!nrst_in)
        ev[2] |=> !ev[2] [*3])
        else $error("Pin interrupt inside dead time.");

    a_irq_flag: assert property ( // see R20
        @(posedge clk_in) disable iff (!nrst_in)
        (|(st.flags & ena)) |=> irq_out)
        else $error("Request missing with flag set.");

    a_level_set: assert property ( // see R6
        @(posedge clk_in) disable iff (!nrst_in)
        (bus_in.wr && bus_in.addr == `GPP_OFS_OSET) |=>
        ((st.out & $past(bus_in.wdata) & PMASK) == ($past(bus_in.wdata) & PMASK)))
        else $error("Drive-level set failed.");

    a_level_flip: assert property ( // see R8
        @(posedge clk_in) disable iff (!nrst_in)
        (bus_in.wr && bus_in.addr == `GPP_OFS_OTGL) |=>
        (st.out == ($past(st.out) ^ ($past(bus_in.wdata) & PMASK))))
        else $error("Drive-level flip failed.");

    a_alias_dir: assert property ( // see R18
        @(posedge clk_in) disable iff (!nrst_in)
        (bus_in.wr && bus_in.addr == `GPP_OFS_ADIR) |=>
        (st.dir == ($past(bus_in.wdata) & PMASK)))
        else $error("Drive-enable alias write failed.");

    a_alias_read: assert property ( // see R18
        @(posedge clk_in) disable iff (!nrst_in)
        (bus_in.rd && bus_in.addr == `GPP_OFS_AOUT) |=> (rdata_out == $past(st.out)))
        else $error("Drive-level alias read failed.");

    a_read_sampled: assert property ( // see R9
        @(posedge clk_in) disable iff (!nrst_in)
        (bus_in.rd && bus_in.addr == `GPP_OFS_IN) |=> (rdata_out == $past(st.smp)))
        else $error("Sampled-level read failed.");

    a_cfg_write: assert property ( // see R12
        @(posedge clk_in) disable iff (!nrst_in)
        (bus_in.wr && bus_in.addr == `GPP_OFS_CFG) |=>
        (st.cfg[0] == ($past(bus_in.wdata) & `GPP_CFG_MASK)))
        else $error("Pin zero configuration write failed.");

    a_slew_follow: assert property ( // see R11
        @(posedge clk_in) disable iff (!nrst_in)
        (bus_in.wr && bus_in.addr == `GPP_OFS_GRP) |=>
        (slew_out == $past(bus_in.wdata[`GPP_GRP_SLR])))
        else $error("Edge-rate limit not applied.");

    a_bufoff_freeze: assert property ( // see R10
        @(posedge clk_in) disable iff (!nrst_in)
        (st.cfg[3][2:0] == gpp_pkg::GPP_BUFOFF && next_st.cfg[3][2:0] == gpp_pkg::GPP_BUFOFF)
        |=> ($stable(st.smp[3]) && !st.ibuf[3]))
        else $error("Sampled bit moved with buffer off.");

    a_override_oe: assert property ( // see R19
        @(posedge clk_in) disable iff (!nrst_in)
        ovr_en[0] |=> (st.pin_oe[0] == $past(ovr_oe[0]) && st.pin_o[0] == $past(ovr_lvl[0])))
        else $error("Peripheral override ignored.");

    a_plain_drive: assert property ( // see R13 R19
        @(posedge clk_in) disable iff (!nrst_in)
        (!ovr_en[1] && PMASK[1]) |=>
        (st.pin_o[1] == ($past(st.out[1]) ^ $past(st.cfg[1][`GPP_CFG_INV]))))
        else $error("Drive level not inverted as configured.");

    a_flag_clear: assert property ( // see R24
        @(posedge clk_in) disable iff (!nrst_in)
        (bus_in.wr && bus_in.addr == `GPP_OFS_FLAG && ev == '0) |=>
        ((st.flags & $past(bus_in.wdata) & PMASK) == '0))
        else $error("Event flag not cleared by a one.");

    a_flag_set: assert property ( // see R20
        @(posedge clk_in) disable iff (!nrst_in)
        (ev != '0) |=> ((st.flags & $past(ev)) == $past(ev)))
        else $error("Sense hit did not set its flag.");

    a_wake_pulse: assert property ( // see R17
        @(posedge clk_in) disable iff (!nrst_in)
        (ev != '0) |=> wake_out)
        else $error("Sense hit raised no wake request.");

    a_irq_clear: assert property ( // see R20
        @(posedge clk_in) disable iff (!nrst_in)
        !(|(st.flags & ena)) |=> !irq_out)
        else $error("Request without an enabled flag.");

    a_fall_hit: assert property ( // see R16
        @(posedge clk_in) disable iff (!nrst_in)
        (st.cfg[2][2:0] == gpp_pkg::GPP_FALL && next_st.cfg[2][2:0] == gpp_pkg::GPP_FALL &&
         st.prev[2] && !v[2] && st.dead[2] == 2'h0) |=> st.flags[2])
        else $error("Falling edge not flagged.");

    a_polarity_edge: assert property ( // see R14
        @(posedge clk_in) disable iff (!nrst_in)
        (st.cfg[2][2:0] == gpp_pkg::GPP_BOTH && next_st.cfg[2][2:0] == gpp_pkg::GPP_BOTH &&
         next_st.cfg[2][`GPP_CFG_INV] != st.cfg[2][`GPP_CFG_INV] &&
         next_st.filt[2] == st.filt[2] && st.dead[2] == 2'h0) |=> st.flags[2])
        else $error("Polarity change made no edge.");

endmodule // gpp_port

// File: dv/gpp_pin_model.sv
// Purpose: Pin-side model that resolves each pad level of the port.
// Assumes: External drivers are enabled per pin by the bench.
// Notes: A pad that nobody drives and that has no pull-up toggles each clock.
`timescale 1ns/1ps

module gpp_pin_model #(
    parameter int NPIN = 8
) (
    input  wire logic            clk_in,
    input  wire logic [NPIN-1:0] pin_out_in,
    input  wire logic [NPIN-1:0] pin_oe_in,
    input  wire logic [NPIN-1:0] pull_in,
    input  wire logic [NPIN-1:0] ext_en_in,
    input  wire logic [NPIN-1:0] ext_val_in,
    output logic      [NPIN-1:0] lvl_out
);
    // ****************************************
    // Pad resolution
    // ****************************************
    logic flt = 1'b0;

    always @(posedge clk_in) begin
        flt <= ~flt;
    end

    always_comb begin
        for (int n = 0; n < NPIN; n++) begin
            if (pin_oe_in[n]) begin
                lvl_out[n] = pin_out_in[n];
            end else if (ext_en_in[n]) begin
                lvl_out[n] = ext_val_in[n];
            end else if (pull_in[n]) begin
                lvl_out[n] = 1'b1;
            end else begin
                lvl_out[n] = flt;
            end
        end
    end
endmodule // gpp_pin_model

// File: dv/test_gpp_port.sv
// Purpose: Self-checking bench of the pin port block.
// Assumes: Eight pins; bus strobes change right after the rising edge.
// Notes: Pads are resolved by the pin model.
`timescale 1ns/1ps

module test_gpp_port;
    // ****************************************
    // Signals
    // ****************************************
    logic              clk_in = 1'b0;
    logic              nrst_in = 1'b1;
    gpp_pkg::gpp_bus_s bus = '0;
    logic [7:0]        rdata, pin_o, pin_oe, pull, ibuf, evt, lvl;
    logic [7:0]        ovr_en = '0, ovr_oe = '0, ovr_lvl = '0, ext_en = '0, ext_val = '0;
    logic              slew, irq, wake;
    int                num_errors = 0;
    int                checked = 0;
    int                wakes = 0;
    int                w = 0;
    gpp_pkg::gpp_sense_e codes[4] = '{gpp_pkg::GPP_BOTH, gpp_pkg::GPP_RISE,
                                      gpp_pkg::GPP_FALL, gpp_pkg::GPP_LOW};
    logic [3:0]        fexp = 4'b1101;
    logic [3:0]        rexp = 4'b0011;

    always #2.5 clk_in = ~clk_in;

    always @(posedge clk_in) begin
        if (wake === 1'b1) wakes <= wakes + 1;
    end

    gpp_port #(.NPIN(8)) u_dut (.clk_in(clk_in), .nrst_in(nrst_in), .bus_in(bus),
        .rdata_out(rdata), .pin_in(lvl), .pin_out(pin_o), .pin_oe_out(pin_oe),
        .pull_out(pull), .ibuf_en_out(ibuf), .evt_out(evt), .slew_out(slew),
        .irq_out(irq), .wake_out(wake), .ovr_en_in(ovr_en), .ovr_oe_in(ovr_oe),
        .ovr_lvl_in(ovr_lvl));

    gpp_pin_model #(.NPIN(8)) u_pins (.clk_in(clk_in), .pin_out_in(pin_o),
        .pin_oe_in(pin_oe), .pull_in(pull), .ext_en_in(ext_en), .ext_val_in(ext_val),
        .lvl_out(lvl));

    // ****************************************
    // Tasks
    // ****************************************
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        @(posedge clk_in);
        bus.addr <= a;
        bus.wdata <= d;
        bus.wr <= 1'b1;
        @(posedge clk_in);
        bus.wr <= 1'b0;
    endtask

    task automatic rdc(input logic [4:0] a, input logic [7:0] exp);
        @(posedge clk_in);
        bus.addr <= a;
        bus.rd <= 1'b1;
        @(posedge clk_in);
        bus.rd <= 1'b0;
        #1;
        chk(rdata, exp);
    endtask

    task automatic pad(input logic [7:0] v);
        @(posedge clk_in);
        ext_val <= v;
        repeat (8) @(posedge clk_in);
    endtask

    task automatic finish_test;
        $display("Counts: %0d compares, %0d mismatches", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // ****************************************
    // Tests
    // ****************************************
    initial begin
        #50000;
        num_errors++;
        $display("MISMATCH at %0t: watchdog expired", $time);
        finish_test();
    end

    initial begin
        nrst_in <= 1'b0;
        #1;
        chk(pin_oe, 8'h00);
        chk(ibuf, 8'hFF);
        repeat (2) @(posedge clk_in);
        nrst_in <= 1'b1;
        for (int n = 0; n < 8; n++) wr(5'h10 + 5'(n), 8'h78 | 8'(n % 6));
        for (int n = 0; n < 8; n++) rdc(5'h10 + 5'(n), 8'h08 | 8'(n % 6));
        for (int n = 0; n < 8; n++) wr(5'h10 + 5'(n), 8'h00);
        wr(5'h0B, 8'hFF);
        rdc(5'h0B, 8'h00);
        rdc(5'h1F, 8'h00);
        $display("Test config map done");
        wr(5'h01, 8'h05);
        rdc(5'h00, 8'h05);
        wr(5'h02, 8'h01);
        rdc(5'h00, 8'h04);
        wr(5'h03, 8'h0C);
        rdc(5'h03, 8'h08);
        chk(pin_oe, 8'h08);
        wr(5'h18, 8'hFF);
        rdc(5'h00, 8'hFF);
        $display("Test direction done");
        wr(5'h05, 8'h81);
        rdc(5'h04, 8'h81);
        wr(5'h06, 8'h01);
        rdc(5'h19, 8'h80);
        wr(5'h07, 8'h03);
        rdc(5'h04, 8'h83);
        wr(5'h1A, 8'h01);
        rdc(5'h04, 8'h82);
        wr(5'h1A, 8'h01);
        wr(5'h08, 8'h01);
        rdc(5'h04, 8'h82);
        chk(pin_o, 8'h82);
        @(posedge clk_in);
        ovr_en <= 8'h01;
        ovr_oe <= 8'h01;
        ovr_lvl <= 8'h01;
        repeat (3) @(posedge clk_in);
        chk(pin_o, 8'h83);
        ovr_en <= 8'h00;
        $display("Test levels done");
        wr(5'h02, 8'hFF);
        ext_en <= 8'hFF;
        pad(8'hA5);
        rdc(5'h08, 8'hA5);
        rdc(5'h1A, 8'hA5);
        wr(5'h10, 8'h08);
        repeat (2) @(posedge clk_in);
        chk(pull, 8'h01);
        wr(5'h01, 8'h01);
        repeat (8) @(posedge clk_in);
        chk(pull, 8'h00);
        rdc(5'h08, 8'hA4);
        wr(5'h02, 8'h01);
        wr(5'h10, 8'h00);
        wr(5'h11, 8'h80);
        repeat (8) @(posedge clk_in);
        rdc(5'h08, 8'hA7);
        chk(pin_o, 8'h80);
        wr(5'h11, 8'h00);
        wr(5'h13, 8'h04);
        pad(8'hAD);
        chk(ibuf, 8'hF7);
        chk(evt, 8'hA5);
        rdc(5'h08, 8'hA5);
        wr(5'h13, 8'h00);
        repeat (8) @(posedge clk_in);
        rdc(5'h08, 8'hAD);
        wr(5'h0A, 8'h01);
        rdc(5'h0A, 8'h01);
        chk({7'h00, slew}, 8'h01);
        $display("Test inputs done");
        for (int i = 0; i < 4; i++) begin
            wr(5'h12, {5'h00, codes[i]});
            repeat (8) @(posedge clk_in);
            wr(5'h09, 8'hFF);
            repeat (8) @(posedge clk_in);
            rdc(5'h09, 8'h00);
            w = wakes;
            pad(8'hA9);
            rdc(5'h09, {5'h00, fexp[i], 2'h0});
            chk({7'h00, irq}, {7'h00, fexp[i]});
            chk({7'h00, wakes != w}, {7'h00, fexp[i]});
            wr(5'h1B, 8'hFF);
            if (i != 3) rdc(5'h09, 8'h00);
            pad(8'hAD);
            if (i != 3) rdc(5'h09, {5'h00, rexp[i], 2'h0});
        end
        wr(5'h12, 8'h01);
        wr(5'h09, 8'hFF);
        repeat (8) @(posedge clk_in);
        wr(5'h12, 8'h81);
        rdc(5'h09, 8'h04);
        $display("Test sensing done");
        finish_test();
    end
endmodule // test_gpp_port
